/* design/mcu_irq_pkg.sv */
// Constants, register map and carriers for the interrupt controller
// How it works
// - Enabled sub-source events set multi-function request flag
// - Multi-function call: vector 18H, clears flag, master
// - Service holds other acknowledgments until released
// - Return-from-interrupt sets master enable
// - Pending requests serviced on next T2 pulse
// - Fixed priority ext0, ext1, tmr0, tmr1, serial, multi
// - Master enable cleared masks every source
// - Serial completion sets flag, calls 14H
// - Sub-source status flags sticky until software clears
// - Control 0 holds master and three enables
// - Control 0 holds three request flags
// - Control 1 holds three enables, bits 3,7 zero
// - Control 1 holds three request flags
// - Remote control holds three sub enables
// - Remote run bit starts or clears counter
// - Remote clock source: system or system/4
// - Remote prescale divides base by 2^5..2^8
// - Status bit 4 enables RTC; 5-7 zero
// - Service pushes only program counter
// - No acknowledgment while stack is full
package mcu_irq_pkg;

  // ****************************************
  // Register map (index, byte address = 4 * index)
  // ****************************************
  localparam logic [9:0]  IDX_CTL0  = 10'h00b;
  localparam logic [9:0]  IDX_CTL1  = 10'h01e;
  localparam logic [9:0]  IDX_REMOTE_TIMER_CONTROL  = 10'h021;
  localparam logic [9:0]  IDX_MFS   = 10'h029;
  localparam logic [11:0] ADDR_CTL0 = {IDX_CTL0, 2'h0};
  localparam logic [11:0] ADDR_CTL1 = {IDX_CTL1, 2'h0};
  localparam logic [11:0] ADDR_REMOTE_TIMER_CONTROL = {IDX_REMOTE_TIMER_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_MFS  = {IDX_MFS, 2'h0};
  localparam logic [7:0]  RST_REG   = 8'h00;

  // ****************************************
  // Sources in priority order, highest first
  // ****************************************
  localparam int NSRC    = 6;
  localparam int SRC_SER = 4;
  localparam int SRC_MF  = 5;
  localparam logic [7:0] VEC_TABLE [NSRC] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  localparam int EN_BIT   [NSRC] = '{1, 2, 3, 0, 1, 2};
  localparam int FLAG_BIT [NSRC] = '{4, 5, 6, 4, 5, 6};
  localparam logic [NSRC-1:0] IN_CTL1 = 6'h38;
  localparam int B_MASTER = 0;

  // ****************************************
  // Remote timer control and sub-source status
  // ****************************************
  localparam int B_RISE_EN = 1;
  localparam int B_FALL_EN = 2;
  localparam int B_OVF_EN  = 3;
  localparam int B_RUN     = 4;
  localparam int B_CLKSRC  = 5;
  localparam int B_PRE     = 6;
  localparam logic [7:0] REMOTE_TIMER_CONTROL_MASK = 8'hfe;
  localparam int F_OVF     = 0;
  localparam int F_RTC     = 1;
  localparam int F_RISE    = 2;
  localparam int F_FALL    = 3;
  localparam int B_RTC_EN  = 4;
  localparam logic [7:0] PRE_MASK [4] = '{8'h1f, 8'h3f, 8'h7f, 8'hff};
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [7:0] CNT_MAX   = 8'hff;

  // ****************************************
  // Bus answers and carriers
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axil_m2s_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_s2m_s;

  typedef struct packed {
    logic t2;
    logic stack_full;
    logic return_from_interrupt;
  } cpu_in_s;

  typedef struct packed {
    logic ext0;
    logic ext1;
    logic tmr0;
    logic tmr1;
    logic serial;
    logic rtc;
  } evt_s;

endpackage

/* design/mcu_interrupt_controller.sv */
// Interrupt controller with multi-function merge and remote timer
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module mcu_interrupt_controller (
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire mcu_irq_pkg::axil_m2s_s i_axil,
  output      mcu_irq_pkg::axil_s2m_s o_axil,
  input  wire mcu_irq_pkg::cpu_in_s   i_cpu,
  input  wire mcu_irq_pkg::evt_s      i_evt,
  input  wire logic                   i_remote_pin,
  output logic                        o_call,
  output logic [7:0]                  o_vector,
  output logic                        o_in_service,
  output logic [7:0]                  o_remote_count
);
  import mcu_irq_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]      bresp_r, rresp_r;
  logic [31:0]     rdata_r;
  logic            aw_held_r, w_held_r, wstrb0_r;
  logic [11:0]     awaddr_r;
  logic [7:0]      wbyte_r;
  logic            wr_go, wr_c0, wr_c1, wr_remote_timer_control, wr_mfs;
  logic            emi_r, in_service_r, call_r;
  logic [7:0]      vector_r;
  wire  [NSRC-1:0] en_w;
  wire  [NSRC-1:0] req_w;
  logic [NSRC-1:0] src_evt, grant;
  logic            ok_c;
  logic [7:0]      gvec;
  logic [7:0]      remote_timer_control_r;
  logic [3:0]      mfs_r;
  logic            rtc_en_r;
  logic [3:0]      sub_evt, sub_en;
  logic            mf_set;
  logic [7:0]      ctl0_v, ctl1_v;
  logic            pin_s1, pin_s2, pin_s3, pin_lvl_r;
  logic [1:0]      div4_r;
  logic [7:0]      pre_r, cnt_r;
  logic            base_en, tick, ovf, rise, fall;

  // ****************************************
  // Register bus
  // ****************************************
  assign o_axil = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                    bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                    rdata: rdata_r, rresp: rresp_r};

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_CTL0) || (a == ADDR_CTL1) || (a == ADDR_REMOTE_TIMER_CONTROL) || (a == ADDR_MFS);
  endfunction

  // Address and data taken in either order, answered once both held
  assign wr_go   = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_c0   = wr_go & wstrb0_r & (awaddr_r == ADDR_CTL0);
  assign wr_c1   = wr_go & wstrb0_r & (awaddr_r == ADDR_CTL1);
  assign wr_remote_timer_control = wr_go & wstrb0_r & (awaddr_r == ADDR_REMOTE_TIMER_CONTROL);
  assign wr_mfs  = wr_go & wstrb0_r & (awaddr_r == ADDR_MFS);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wbyte_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (i_axil.awvalid && awready_r) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r  <= i_axil.awaddr;
      end
      if (i_axil.wvalid && wready_r) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        wbyte_r  <= i_axil.wdata[7:0];
        wstrb0_r <= i_axil.wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && i_axil.bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read images; bit 7 of control 0 and unused bits read zero
  always_comb begin
    ctl0_v = RST_REG;
    ctl1_v = RST_REG;
    ctl0_v[B_MASTER] = emi_r;
    for (int k = 0; k < NSRC; k++) begin
      if (IN_CTL1[k]) begin
        ctl1_v[EN_BIT[k]]   = en_w[k];
        ctl1_v[FLAG_BIT[k]] = req_w[k];
      end else begin
        ctl0_v[EN_BIT[k]]   = en_w[k];
        ctl0_v[FLAG_BIT[k]] = req_w[k];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (i_axil.arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= is_mapped(i_axil.araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (i_axil.araddr)
        ADDR_CTL0: rdata_r <= {24'h000000, ctl0_v};
        ADDR_CTL1: rdata_r <= {24'h000000, ctl1_v};
        ADDR_REMOTE_TIMER_CONTROL: rdata_r <= {24'h000000, remote_timer_control_r};
        ADDR_MFS:  rdata_r <= {24'h000000, 3'h0, rtc_en_r, mfs_r};
        default:   rdata_r <= '0;
      endcase
    end else if (rvalid_r && i_axil.rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // Enables and request flags per source
  // ****************************************
  assign src_evt = {mf_set, i_evt.serial, i_evt.tmr1, i_evt.tmr0, i_evt.ext1, i_evt.ext0};

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    logic en_q, req_q;
    wire  wr_reg = IN_CTL1[i] ? wr_c1 : wr_c0;
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        en_q  <= 1'b0;
        req_q <= 1'b0;
      end else begin
        if (wr_reg) begin
          en_q <= wbyte_r[EN_BIT[i]];
        end
        // New event beats a clear in the same cycle
        if (src_evt[i]) begin
          req_q <= 1'b1;
        end else if (wr_reg) begin
          req_q <= wbyte_r[FLAG_BIT[i]];
        end else if (grant[i]) begin
          req_q <= 1'b0;
        end
      end
    end
    assign en_w[i]  = en_q;
    assign req_w[i] = req_q;
  end

  // ****************************************
  // Arbitration on the T2 phase pulse
  // ****************************************
  assign ok_c = i_cpu.t2 & emi_r & ~in_service_r & ~i_cpu.stack_full;

  always_comb begin
    grant = '0;
    gvec  = VEC_TABLE[0];
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (ok_c && req_w[k] && en_w[k]) begin
        grant    = '0;
        grant[k] = 1'b1;
        gvec     = VEC_TABLE[k];
      end
    end
  end

  // Only the program counter goes on the stack; status is software's job
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      call_r   <= 1'b0;
      vector_r <= '0;
    end else begin
      call_r <= |grant;
      if (|grant) begin
        vector_r <= gvec;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      emi_r <= 1'b0;
    end else if (i_cpu.return_from_interrupt) begin
      emi_r <= 1'b1;
    end else if (|grant) begin
      emi_r <= 1'b0;
    end else if (wr_c0) begin
      emi_r <= wbyte_r[B_MASTER];
    end
  end

  // Hold released by return, or by software re-arming the master enable while the stack is not full
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_service_r <= 1'b0;
    end else if (i_cpu.return_from_interrupt || (wr_c0 && wbyte_r[B_MASTER] && !i_cpu.stack_full)) begin
      in_service_r <= 1'b0;
    end else if (|grant) begin
      in_service_r <= 1'b1;
    end
  end

  assign o_call       = call_r;
  assign o_vector     = vector_r;
  assign o_in_service = in_service_r;

  // ****************************************
  // Multi-function sub-sources
  // ****************************************
  assign sub_evt = {fall, rise, i_evt.rtc, ovf};
  assign sub_en  = {remote_timer_control_r[B_FALL_EN], remote_timer_control_r[B_RISE_EN], rtc_en_r, remote_timer_control_r[B_OVF_EN]};
  assign mf_set  = |(sub_evt & sub_en);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mfs_r    <= '0;
      rtc_en_r <= 1'b0;
      remote_timer_control_r   <= RST_REG;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (sub_evt[k]) begin
          mfs_r[k] <= 1'b1;
        end else if (wr_mfs) begin
          mfs_r[k] <= wbyte_r[k];
        end
      end
      if (wr_mfs) begin
        rtc_en_r <= wbyte_r[B_RTC_EN];
      end
      if (wr_remote_timer_control) begin
        remote_timer_control_r <= wbyte_r & REMOTE_TIMER_CONTROL_MASK;
      end
    end
  end

  // ****************************************
  // Remote control timer
  // ****************************************
  // Level moves only once stages two and three agree, so a metastable first stage never leaks
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      pin_s3    <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_s1 <= i_remote_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_lvl_r <= pin_s2;
      end
    end
  end

  // Level starts low, so a quiet low pin gives no false edge after reset
  assign rise    = pin_s2 & pin_s3 & ~pin_lvl_r;
  assign fall    = ~pin_s2 & ~pin_s3 & pin_lvl_r;
  assign base_en = remote_timer_control_r[B_CLKSRC] | (div4_r == DIV4_LAST);
  assign tick    = base_en & ((pre_r & PRE_MASK[remote_timer_control_r[B_PRE+:2]]) == PRE_MASK[remote_timer_control_r[B_PRE+:2]]);
  assign ovf     = tick & (cnt_r == CNT_MAX);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div4_r <= '0;
      pre_r  <= '0;
      cnt_r  <= '0;
    end else if (!remote_timer_control_r[B_RUN]) begin
      div4_r <= '0;
      pre_r  <= '0;
      cnt_r  <= '0;
    end else begin
      div4_r <= div4_r + 2'h1;
      if (base_en) begin
        pre_r <= pre_r + 8'h01;
      end
      if (tick) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  assign o_remote_count = cnt_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_mf_alone;
    ok_c && req_w[SRC_MF] && en_w[SRC_MF] && !(|(req_w[SRC_MF-1:0] & en_w[SRC_MF-1:0]))
      && !src_evt[SRC_MF] && !i_cpu.return_from_interrupt && !wr_c1;
  endsequence

  sequence s_mf_called;
    o_call && o_vector == VEC_TABLE[SRC_MF] && !req_w[SRC_MF] && !emi_r;
  endsequence

  AST_MF_CALL: assert property (s_mf_alone |=> s_mf_called)
    else $error("multi-function call wrong");
  AST_MF_SET: assert property (mf_set |=> req_w[SRC_MF])
    else $error("multi-function flag not set");
  AST_DISABLED_SUB: assert property (i_evt.rtc && !rtc_en_r && !req_w[SRC_MF] && !wr_c1
    && !(|(sub_evt[3:2] & sub_en[3:2])) && !(ovf && sub_en[0])
    |=> mfs_r[F_RTC] && !req_w[SRC_MF])
    else $error("disabled sub-source raised request");
  AST_HOLD: assert property (in_service_r |=> !o_call)
    else $error("call while in service");
  AST_RETURN_FROM_INTERRUPT: assert property (i_cpu.return_from_interrupt |=> emi_r && !in_service_r)
    else $error("return did not re-enable");
  AST_T2: assert property (o_call |-> $past(i_cpu.t2) && $past(emi_r))
    else $error("call outside T2");
  AST_PRIO: assert property (ok_c && req_w[0] && en_w[0] |=> o_call && o_vector == VEC_TABLE[0])
    else $error("priority broken");
  AST_MASK: assert property (!emi_r |=> !o_call)
    else $error("call with master off");
  AST_STACK: assert property (i_cpu.stack_full |=> !o_call)
    else $error("call with stack full");
  AST_SER: assert property (i_evt.serial |=> req_w[SRC_SER])
    else $error("serial flag lost");
  AST_STICKY: assert property (mfs_r[F_OVF] && !wr_mfs |=> mfs_r[F_OVF])
    else $error("status flag cleared itself");
  AST_RUN: assert property (!remote_timer_control_r[B_RUN] |=> cnt_r == '0 && pre_r == '0)
    else $error("stopped timer not cleared");
  AST_EDGE: assert property (rise |-> $past(i_remote_pin, 2) && $past(i_remote_pin, 3)
    && !$past(i_remote_pin, 4))
    else $error("edge not from synchronised pin");

  // ****************************************
  // Service, timer and register image checks
  // ****************************************
  // Writes excluded: a software write to flags outranks the grant's clear, and re-arming the master enable outranks the grant's hold
  sequence s_ser_alone;
    ok_c && req_w[SRC_SER] && en_w[SRC_SER] && !(|(req_w[SRC_SER-1:0] & en_w[SRC_SER-1:0]))
      && !i_evt.serial && !i_cpu.return_from_interrupt && !wr_c0 && !wr_c1;
  endsequence

  sequence s_ser_called;
    o_call && o_vector == VEC_TABLE[SRC_SER] && !req_w[SRC_SER] && in_service_r && !emi_r;
  endsequence

  AST_SER_CALL: assert property (s_ser_alone |=> s_ser_called)
    else $error("serial call wrong");
  AST_GRANT_HOLD: assert property (|grant && !i_cpu.return_from_interrupt && !wr_c0
    |=> o_call && !emi_r && in_service_r)
    else $error("grant did not mask");
  AST_FLAG_KEEP: assert property (req_w[SRC_SER] && !grant[SRC_SER] && !wr_c1 |=> req_w[SRC_SER])
    else $error("serial flag dropped");
  AST_OVF_STATUS: assert property (ovf |=> mfs_r[F_OVF])
    else $error("overflow status lost");
  AST_OVF_REQ: assert property (ovf && remote_timer_control_r[B_OVF_EN] |=> req_w[SRC_MF])
    else $error("overflow request lost");
  AST_COUNT_STEP: assert property (remote_timer_control_r[B_RUN] && tick |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("count step wrong");
  AST_DIV4: assert property (remote_timer_control_r[B_RUN] && !remote_timer_control_r[B_CLKSRC] && base_en && !wr_remote_timer_control |=> !base_en)
    else $error("quarter rate enable too fast");
  AST_CTL0_READ: assert property (i_axil.arvalid && arready_r && i_axil.araddr == ADDR_CTL0
    |=> rdata_r[7:0] == {1'b0, $past(req_w[2:0]), $past(en_w[2:0]), $past(emi_r)})
    else $error("control 0 image wrong");
  AST_CTL1_READ: assert property (i_axil.arvalid && arready_r && i_axil.araddr == ADDR_CTL1
    |=> rdata_r[7:0] == {1'b0, $past(req_w[5:3]), 1'b0, $past(en_w[5:3])})
    else $error("control 1 image wrong");
  AST_MFS_READ: assert property (i_axil.arvalid && arready_r && i_axil.araddr == ADDR_MFS
    |=> rdata_r[7:0] == {3'h0, $past(rtc_en_r), $past(mfs_r)})
    else $error("status image wrong");

endmodule // mcu_interrupt_controller

/* sim/cpu_seq_model.sv */
// CPU sequencer model: phase pulses, stack depth, returns
`timescale 1ns/1ps
module cpu_seq_model #(
  parameter int DEPTH = 8
) (
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_call,
  input  wire logic            i_ret,
  input  wire logic            i_busy_stack,
  output mcu_irq_pkg::cpu_in_s o_cpu
);
  import mcu_irq_pkg::*;
  logic [1:0] ph_r;
  int         depth_r;
  // ****************************************
  // Phase and stack
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  // Call pushes the program counter alone
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      depth_r <= 0;
    end else begin
      depth_r <= depth_r + (i_call ? 1 : 0) - ((i_ret && depth_r > 0) ? 1 : 0);
    end
  end
  // One phase-two pulse per four clocks; extra hold stands in for nested subroutine calls
  assign o_cpu = '{t2: (ph_r == 2'h1), stack_full: (depth_r >= DEPTH) || i_busy_stack, return_from_interrupt: i_ret};
endmodule // cpu_seq_model

/* sim/mcu_interrupt_controller_tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module mcu_interrupt_controller_tb;
  import mcu_irq_pkg::*;
  // ****************************************
  // Wiring
  // ****************************************
  logic       i_clk, i_resetn, pin, ret_req, busy_stk, call, insvc, t2_d;
  axil_m2s_s  m2s;
  axil_s2m_s  s2m;
  cpu_in_s    cpu;
  evt_s       evt;
  logic [7:0] vec, rcnt;
  int         err_count, checks_done;
  logic [7:0] vexp [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

  mcu_interrupt_controller uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_axil(m2s), .o_axil(s2m),
    .i_cpu(cpu), .i_evt(evt), .i_remote_pin(pin), .o_call(call), .o_vector(vec),
    .o_in_service(insvc), .o_remote_count(rcnt));
  cpu_seq_model cpu_m (.i_clk(i_clk), .i_resetn(i_resetn), .i_call(call), .i_ret(ret_req),
    .i_busy_stack(busy_stk), .o_cpu(cpu));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) t2_d <= cpu.t2;
  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic fail(input string m);
    err_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e) fail(m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge i_clk);
    m2s <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'hf, bready: 1'b1,
             default: '0};
    // Waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge i_clk);
      aw = aw | s2m.awready;
      w = w | s2m.wready;
      if (aw) m2s.awvalid <= 1'b0;
      if (w) m2s.wvalid <= 1'b0;
    end while (!(aw && w));
    do begin
      @(posedge i_clk);
    end while (!s2m.bvalid);
    m2s.bready <= 1'b0;
    r = s2m.bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge i_clk);
    m2s <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge i_clk);
      if (s2m.arready) m2s.arvalid <= 1'b0;
    end while (!s2m.rvalid);
    m2s.rready <= 1'b0;
    d = s2m.rdata[7:0];
    r = s2m.rresp;
  endtask
  task automatic wchk(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_byte({6'h0, r}, {6'h0, RESP_OKAY}, "write response");
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_byte({6'h0, r}, {6'h0, RESP_OKAY}, "read response");
    chk_byte(d, e, $sformatf("register %h", a));
  endtask
  task automatic pulse(input evt_s e);
    @(posedge i_clk);
    evt <= e;
    @(posedge i_clk);
    evt <= '0;
  endtask
  task automatic ret_pulse;
    @(posedge i_clk);
    ret_req <= 1'b1;
    @(posedge i_clk);
    ret_req <= 1'b0;
  endtask
  task automatic wait_call(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!call && n < 64);
    chk_bit(call, 1'b1, "call missing");
    chk_bit(t2_d, 1'b1, "grant off phase two");
    chk_byte(vec, e, "vector");
    chk_bit(insvc, 1'b1, "service level");
  endtask
  task automatic no_call(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      seen = seen | call;
    end
    chk_bit(seen, 1'b0, "unexpected call");
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] d;
    logic [1:0] r;
    rchk(ADDR_CTL0, 8'h00);
    rchk(ADDR_CTL1, 8'h00);
    rchk(ADDR_REMOTE_TIMER_CONTROL, 8'h00);
    rchk(ADDR_MFS, 8'h00);
    wchk(ADDR_CTL1, 8'hff);
    rchk(ADDR_CTL1, 8'h77);
    wchk(ADDR_CTL1, 8'h00);
    wchk(ADDR_REMOTE_TIMER_CONTROL, 8'hef);
    rchk(ADDR_REMOTE_TIMER_CONTROL, 8'hee);
    wchk(ADDR_MFS, 8'hff);
    rchk(ADDR_MFS, 8'h1f);
    wchk(ADDR_CTL0, 8'h7e); // Test bit kept zero
    rchk(ADDR_CTL0, 8'h7e);
    wchk(ADDR_CTL0, 8'h00);
    wchk(ADDR_REMOTE_TIMER_CONTROL, 8'h00);
    wchk(ADDR_MFS, 8'h00);
    wr(12'h000, 8'h55, r);
    chk_byte({6'h0, r}, {6'h0, RESP_SLVERR}, "unmapped write");
    rd(12'h000, d, r);
    chk_byte({6'h0, r}, {6'h0, RESP_SLVERR}, "unmapped read");
    $display("test registers done");
  endtask
  task automatic t_prio;
    wchk(ADDR_CTL1, 8'h03);
    wchk(ADDR_CTL0, 8'h0e);
    pulse(evt_s'(6'h3e));
    no_call(16);
    rchk(ADDR_CTL0, 8'h7e);
    rchk(ADDR_CTL1, 8'h33);
    wchk(ADDR_CTL0, 8'h7f);
    for (int i = 0; i < 5; i++) begin
      wait_call(vexp[i]);
      if (i == 0) rchk(ADDR_CTL0, 8'h6e);
      no_call(8);
      ret_pulse();
    end
    rchk(ADDR_CTL0, 8'h0f);
    rchk(ADDR_CTL1, 8'h03);
    $display("test priority done");
  endtask
  task automatic t_mf;
    wchk(ADDR_CTL0, 8'h00);
    wchk(ADDR_CTL1, 8'h04);
    pulse(evt_s'(6'h01));
    rchk(ADDR_MFS, 8'h02);
    rchk(ADDR_CTL1, 8'h04);
    rchk(ADDR_MFS, 8'h02);
    wchk(ADDR_MFS, 8'h10); // Software clears status
    pulse(evt_s'(6'h01));
    rchk(ADDR_CTL1, 8'h44);
    wchk(ADDR_MFS, 8'h10);
    wchk(ADDR_REMOTE_TIMER_CONTROL, 8'h02);
    tick(1);
    pin <= 1'b1;
    tick(8);
    rchk(ADDR_MFS, 8'h14);
    wchk(ADDR_CTL0, 8'h01);
    wait_call(8'h18);
    ret_pulse();
    rchk(ADDR_CTL1, 8'h04);
    tick(1);
    pin <= 1'b0;
    tick(8);
    rchk(ADDR_MFS, 8'h1c);
    rchk(ADDR_CTL1, 8'h04);
    $display("test multi-function done");
  endtask
  task automatic t_stack;
    busy_stk <= 1'b1;
    wchk(ADDR_CTL0, 8'h03);
    pulse(evt_s'(6'h20));
    no_call(16);
    tick(1);
    busy_stk <= 1'b0;
    wait_call(8'h04);
    // Master re-armed while stack full: hold must stay, so only the hold blocks ext1
    busy_stk <= 1'b1;
    wchk(ADDR_CTL0, 8'h07);
    busy_stk <= 1'b0;
    pulse(evt_s'(6'h10));
    no_call(16);
    wchk(ADDR_CTL0, 8'h27);
    wait_call(8'h08);
    ret_pulse();
    ret_pulse();
    rchk(ADDR_CTL0, 8'h07);
    $display("test stack done");
  endtask
  task automatic t_timer;
    logic [7:0] cfg [5] = '{8'h30, 8'h70, 8'hb0, 8'hf0, 8'h10};
    int         per [5] = '{32, 64, 128, 256, 128};
    for (int i = 0; i < 5; i++) begin
      wchk(ADDR_REMOTE_TIMER_CONTROL, cfg[i]);
      tick(per[i] * 4);
      chk_bit(rcnt >= 8'h03 && rcnt <= 8'h05, 1'b1, "count rate");
      wchk(ADDR_REMOTE_TIMER_CONTROL, 8'h00);
      tick(2);
      chk_byte(rcnt, 8'h00, "count clear");
    end
    wchk(ADDR_CTL0, 8'h00);
    wchk(ADDR_CTL1, 8'h04);
    wchk(ADDR_MFS, 8'h00);
    wchk(ADDR_REMOTE_TIMER_CONTROL, 8'h38);
    tick(8250);
    rchk(ADDR_MFS, 8'h01);
    rchk(ADDR_CTL1, 8'h44);
    wchk(ADDR_REMOTE_TIMER_CONTROL, 8'h00);
    $display("test timer done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    err_count = 0;
    checks_done = 0;
    i_resetn = 1'b0;
    m2s = '0;
    evt = '0;
    pin = 1'b0;
    ret_req = 1'b0;
    busy_stk = 1'b0;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk_bit(insvc, 1'b0, "service at reset");
    t_regs();
    t_prio();
    t_mf();
    t_stack();
    t_timer();
    final_report();
  end
  initial begin
    #(8 * 30000);
    fail("watchdog");
    final_report();
  end
endmodule // mcu_interrupt_controller_tb
